/* File: shared/cldio_map.svh */
// Register offsets, field positions, widths, counts and codes for the control-line digital I/O block
`ifndef CLDIO_MAP_SVH
`define CLDIO_MAP_SVH
`define CLDIO_OFS_CTRL 8'h00
`define CLDIO_OFS_INCFG 8'h04
`define CLDIO_OFS_OUTCFG 8'h08
`define CLDIO_OFS_STATUS 8'h0c
`define CLDIO_OFS_LATCH 8'h10
`define CLDIO_OFS_ALARM 8'h14
`define CLDIO_OFS_IRQSTAT 8'h18
`define CLDIO_OFS_IRQEN 8'h1c
`define CLDIO_OFS_IRQCLR 8'h20
`define CLDIO_OFS_ACK 8'h24
`define CLDIO_OFS_NOTE 8'h28
`define CLDIO_NUM_IN 3
`define CLDIO_NUM_OUT 2
`define CLDIO_INCFG_W 8
`define CLDIO_LATCH_LSB 0
`define CLDIO_INV_BIT 2
`define CLDIO_TRIG_LSB 3
`define CLDIO_MANUAL_BIT 5
`define CLDIO_NOTE_LSB 0
`define CLDIO_ENIN_LSB 0
`define CLDIO_ENOUT_LSB 3
`define CLDIO_PROFILE_BIT 5
`define CLDIO_OUTVAL_LSB 8
`define CLDIO_FS_W 2
`define CLDIO_OUTCFG_W 16
`define CLDIO_IRQ_LATCH_LSB 0
`define CLDIO_IRQ_TRIG_LSB 3
`define CLDIO_IRQ_CLR_LSB 6
`define CLDIO_IRQ_W 9
`define CLDIO_SEV_CRITICAL 3'h2
`define CLDIO_HTRANS_NONSEQ 2'h2
`define CLDIO_HSIZE_WORD 3'h2
`endif

/* File: shared/cldio_pkg.sv */
// Types for the control-line digital I/O block
package cldio_pkg;
  typedef enum logic [1:0] {LatchNone, LatchRise, LatchFall} cldio_latch_t;
  typedef enum logic [1:0] {TrigOff, TrigInactive, TrigActive} cldio_trig_t;
  typedef enum logic [1:0] {FsHold, FsActivate, FsDeactivate} cldio_fs_t;
endpackage

/* File: rtl/cldio_in_chan.sv */
// One digital input channel: sync, polarity, latch and alarm
`timescale 1ns/100ps
`default_nettype none
`include "cldio_map.svh"
module cldio_in_chan
  import cldio_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic lineIn,
  input wire logic chanOn,
  input wire logic invert,
  input wire cldio_pkg::cldio_latch_t latchSel,
  input wire cldio_pkg::cldio_trig_t trigSel,
  input wire logic manualClear,
  input wire logic latchClr,
  input wire logic alarmAck,
  output logic level,
  output logic latched,
  output logic alarm,
  output logic latchEvt,
  output logic trigEvt,
  output logic clrEvt
);
  logic sync1_q, sync2_q, prev_q, primed_q;
  logic latch_q, alarm_q;
  wire logic lvl = sync2_q ^ invert;
  wire logic rise = chanOn && primed_q && lvl && !prev_q;
  wire logic fall = chanOn && primed_q && !lvl && prev_q;
  wire logic latchHit = (latchSel == LatchRise && rise) || (latchSel == LatchFall && fall);
  wire logic trigHit = (trigSel == TrigInactive && fall) || (trigSel == TrigActive && rise);
  wire logic autoRel = !manualClear && alarm_q &&
    ((trigSel == TrigInactive && lvl) || (trigSel == TrigActive && !lvl) || trigSel == TrigOff);
  wire logic manRel = manualClear && alarm_q && alarmAck;
  wire logic doTrig = trigHit && !alarm_q;
  wire logic doRel = (autoRel || manRel) && !trigHit;
  always_ff @(posedge core_clk)
  begin
    sync1_q <= lineIn;
    sync2_q <= sync1_q;
    if (rst)
    begin
      prev_q <= 1'b0;
      primed_q <= 1'b0;
      latch_q <= 1'b0;
      alarm_q <= 1'b0;
    end
    else
    begin
      prev_q <= lvl;
      primed_q <= chanOn;
      latch_q <= latchHit ? 1'b1 : (latchClr ? 1'b0 : latch_q);
      if (doTrig)
        alarm_q <= 1'b1;
      else if (doRel)
        alarm_q <= 1'b0;
    end
  end
  assign level = chanOn && lvl;
  assign latched = latch_q;
  assign alarm = alarm_q;
  assign latchEvt = latchHit && !latch_q;
  assign trigEvt = doTrig;
  assign clrEvt = doRel;
  manual_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    manualClear && alarm_q && !alarmAck |=> alarm_q)
    else $error("manual alarm released without ack");
  trig_off_a: assert property (@(posedge core_clk) disable iff (rst)
    trigSel == TrigOff |-> !trigEvt)
    else $error("alarm raised with trigger off");
  latch_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    latch_q && !latchClr |=> latch_q)
    else $error("latch dropped without clear");
endmodule
`default_nettype wire

/* File: rtl/cldio_top.sv */
// Control-line digital I/O block with AHB-Lite register slave
// Operation
// - In the control-line profile DSR, DCD, CTS are inputs and DTR, RTS are outputs.
// - Each line has an enable and only enabled lines are sensed or driven.
// - Each input latches none, a rising or a falling transition, default none.
// - An inverted input reports the complement of its level, default off.
// - Trigger is disabled, inactive or active; disabled never alarms, default disabled.
// - Trigger inactive raises the alarm when the input goes inactive.
// - Trigger active raises the alarm when the input goes active.
// - In auto mode, the default, the alarm clears once the input leaves the trigger state.
// - In manual mode an alarm stays set until software acknowledges it.
// - Each enabled notification channel requests on trigger and clear, critical, with a kind flag; when inputs coincide only the lowest-numbered one requests.
// - On the failsafe timeout each output holds, activates or deactivates, default hold.
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "cldio_map.svh"
module cldio_top
  import cldio_pkg::*;
#(
  parameter int NumIn = `CLDIO_NUM_IN,
  parameter int NumOut = `CLDIO_NUM_OUT
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [NumIn-1:0] ctlIn,
  input wire logic failsafeFire,
  output logic [NumOut-1:0] ctlOut,
  output logic [NumOut-1:0] ctlOutOe,
  output logic irq,
  output logic [2:0] noteReq,
  output logic noteIsTrig,
  output logic [2:0] noteSev,
  output logic [1:0] noteChan
);
  import cldio_pkg::*;
  logic [31:0] ctrl_q, inCfg_q, outCfg_q;
  logic [31:0] noteCfg_q;
  logic [`CLDIO_IRQ_W-1:0] irqStat_q, irqEn_q;
  logic [NumOut-1:0] outVal_q, outLine_q, outOe_q;
  logic irq_q;
  logic [2:0] noteReq_q, noteSev_q;
  logic noteIsTrig_q;
  logic [1:0] noteChan_q;
  logic [31:0] hrdata_q;
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic [NumIn-1:0] latchClr, alarmAck, level, latched, alarm, latchEvt, trigEvt, clrEvt;
  logic [2:0] noteMask [NumIn];

  function automatic logic [`CLDIO_INCFG_W-1:0] inField(input logic [31:0] cfg, input int idx);
    inField = cfg[idx*`CLDIO_INCFG_W +: `CLDIO_INCFG_W];
  endfunction

  function automatic cldio_fs_t fsAction(input logic [31:0] cfg, input int idx);
    fsAction = cldio_fs_t'(cfg[idx*`CLDIO_FS_W +: `CLDIO_FS_W]);
  endfunction

  // Bus decode
  wire logic addrPhase = hsel && hready && htrans == `CLDIO_HTRANS_NONSEQ;
  wire logic rdReq = addrPhase && !hwrite;
  wire logic wrReq = addrPhase && hwrite;
  wire logic [7:0] rdAddr = haddr[7:0];
  wire logic wrCtrl = wrPend_q && wrAddr_q == `CLDIO_OFS_CTRL;
  wire logic wrInCfg = wrPend_q && wrAddr_q == `CLDIO_OFS_INCFG;
  wire logic wrOutCfg = wrPend_q && wrAddr_q == `CLDIO_OFS_OUTCFG;
  wire logic wrIrqEn = wrPend_q && wrAddr_q == `CLDIO_OFS_IRQEN;
  wire logic wrIrqClr = wrPend_q && wrAddr_q == `CLDIO_OFS_IRQCLR;
  wire logic wrAck = wrPend_q && wrAddr_q == `CLDIO_OFS_ACK;
  wire logic wrLatchClr = wrPend_q && wrAddr_q == `CLDIO_OFS_LATCH;
  wire logic wrNote = wrPend_q && wrAddr_q == `CLDIO_OFS_NOTE;
  wire logic profileOn = ctrl_q[`CLDIO_PROFILE_BIT];
  wire logic [NumIn-1:0] inEn = ctrl_q[`CLDIO_ENIN_LSB +: NumIn] & {NumIn{profileOn}};
  wire logic [NumOut-1:0] outEn = ctrl_q[`CLDIO_ENOUT_LSB +: NumOut] & {NumOut{profileOn}};
  wire logic [31:0] rdMux =
    rdAddr == `CLDIO_OFS_CTRL ? ctrl_q :
    rdAddr == `CLDIO_OFS_INCFG ? inCfg_q :
    rdAddr == `CLDIO_OFS_OUTCFG ? outCfg_q :
    rdAddr == `CLDIO_OFS_STATUS ? {{(32-NumIn-NumOut){1'b0}}, outLine_q, level} :
    rdAddr == `CLDIO_OFS_LATCH ? {{(32-NumIn){1'b0}}, latched} :
    rdAddr == `CLDIO_OFS_ALARM ? {{(32-NumIn){1'b0}}, alarm} :
    rdAddr == `CLDIO_OFS_IRQSTAT ? {{(32-`CLDIO_IRQ_W){1'b0}}, irqStat_q} :
    rdAddr == `CLDIO_OFS_IRQEN ? {{(32-`CLDIO_IRQ_W){1'b0}}, irqEn_q} :
    rdAddr == `CLDIO_OFS_NOTE ? noteCfg_q :
    32'h0;

  // Bus checks
  rd_idle_a: assert property (@(posedge core_clk) disable iff (rst)
    !rdReq |=> hrdata == 32'h0)
    else $error("read data standing outside a read");
  write_land_a: assert property (@(posedge core_clk) disable iff (rst)
    wrCtrl |=> ctrl_q == $past(hwdata))
    else $error("control write did not land");

  genvar gi;
  generate
    for (gi = 0; gi < NumIn; gi++)
    begin : gIn
      wire logic [`CLDIO_INCFG_W-1:0] cfg = inField(inCfg_q, gi);
      assign latchClr[gi] = wrLatchClr && hwdata[gi];
      assign alarmAck[gi] = wrAck && hwdata[gi];
      wire logic [`CLDIO_INCFG_W-1:0] noteField = inField(noteCfg_q, gi);
      assign noteMask[gi] = noteField[`CLDIO_NOTE_LSB +: 3];
      cldio_in_chan uChan (
        .core_clk(core_clk),
        .rst(rst),
        .lineIn(ctlIn[gi]),
        .chanOn(inEn[gi]),
        .invert(cfg[`CLDIO_INV_BIT]),
        .latchSel(cldio_latch_t'(cfg[`CLDIO_LATCH_LSB +: 2])),
        .trigSel(cldio_trig_t'(cfg[`CLDIO_TRIG_LSB +: 2])),
        .manualClear(cfg[`CLDIO_MANUAL_BIT]),
        .latchClr(latchClr[gi]),
        .alarmAck(alarmAck[gi]),
        .level(level[gi]),
        .latched(latched[gi]),
        .alarm(alarm[gi]),
        .latchEvt(latchEvt[gi]),
        .trigEvt(trigEvt[gi]),
        .clrEvt(clrEvt[gi])
      );
    end
  endgenerate

  // Lowest-numbered input wins the notification slot this cycle
  logic noteHit;
  logic [1:0] noteIdx;
  logic noteTrig;
  logic [2:0] noteMaskSel;
  always_comb
  begin
    noteHit = 1'b0;
    noteIdx = 2'h0;
    noteTrig = 1'b0;
    noteMaskSel = 3'h0;
    for (int i = NumIn - 1; i >= 0; i--)
    begin
      if (trigEvt[i] || clrEvt[i])
      begin
        noteHit = 1'b1;
        noteIdx = 2'(i);
        noteTrig = trigEvt[i];
        noteMaskSel = noteMask[i];
      end
    end
  end

  note_kind_a: assert property (@(posedge core_clk) disable iff (rst)
    noteHit |=> noteIsTrig == $past(noteTrig) && noteChan == $past(noteIdx))
    else $error("notification kind or channel wrong");
  note_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
    !noteHit |=> noteReq == 3'h0 && !noteIsTrig)
    else $error("notification without alarm event");
  note_sev_a: assert property (@(posedge core_clk) disable iff (rst)
    noteReq != 3'h0 |-> noteSev == `CLDIO_SEV_CRITICAL)
    else $error("notification not critical");

  wire logic [`CLDIO_IRQ_W-1:0] irqSet = {clrEvt, trigEvt, latchEvt};
  wire logic [`CLDIO_IRQ_W-1:0] irqClr = wrIrqClr ? hwdata[`CLDIO_IRQ_W-1:0] : '0;
  irq_clr_a: assert property (@(posedge core_clk) disable iff (rst)
    wrIrqClr && irqSet == '0 |=> (irqStat_q & $past(irqClr)) == '0)
    else $error("status bit survived its clear");
  irq_keep_a: assert property (@(posedge core_clk) disable iff (rst)
    irqStat_q[0] && !irqClr[0] |=> irqStat_q[0])
    else $error("status bit dropped without clear");

  // Failsafe action per output
  logic [NumOut-1:0] fsVal;
  always_comb
  begin
    fsVal = outVal_q;
    for (int i = 0; i < NumOut; i++)
    begin
      case (fsAction(outCfg_q, i))
        FsActivate: fsVal[i] = 1'b1;
        FsDeactivate: fsVal[i] = 1'b0;
        default: fsVal[i] = outVal_q[i];
      endcase
    end
  end

  fs_deact_a: assert property (@(posedge core_clk) disable iff (rst)
    failsafeFire && fsAction(outCfg_q, 1) == FsDeactivate |=> !outVal_q[1])
    else $error("failsafe deactivate not applied");
  fs_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    failsafeFire && fsAction(outCfg_q, 0) == FsHold |=> outVal_q[0] == $past(outVal_q[0]))
    else $error("failsafe hold changed the output");

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctrl_q <= 32'h0;
      inCfg_q <= 32'h0;
      outCfg_q <= 32'h0;
      noteCfg_q <= 32'h0;
      irqStat_q <= '0;
      irqEn_q <= '0;
      outVal_q <= '0;
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h0;
      hrdata_q <= 32'h0;
    end
    else
    begin
      wrPend_q <= wrReq;
      wrAddr_q <= haddr[7:0];
      hrdata_q <= rdReq ? rdMux : 32'h0;
      if (wrCtrl)
        ctrl_q <= hwdata;
      if (wrInCfg)
        inCfg_q <= hwdata;
      if (wrOutCfg)
        outCfg_q <= hwdata;
      if (wrNote)
        noteCfg_q <= hwdata;
      if (wrIrqEn)
        irqEn_q <= hwdata[`CLDIO_IRQ_W-1:0];
      irqStat_q <= (irqStat_q & ~irqClr) | irqSet;
      if (failsafeFire)
        outVal_q <= fsVal;
      else if (wrCtrl)
        outVal_q <= hwdata[`CLDIO_OUTVAL_LSB +: NumOut];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      outLine_q <= '0;
      outOe_q <= '0;
      irq_q <= 1'b0;
      noteReq_q <= 3'h0;
      noteIsTrig_q <= 1'b0;
      noteSev_q <= 3'h0;
      noteChan_q <= 2'h0;
    end
    else
    begin
      outLine_q <= outVal_q & outEn;
      outOe_q <= outEn;
      irq_q <= |(irqStat_q & irqEn_q);
      noteReq_q <= noteHit ? noteMaskSel : 3'h0;
      noteIsTrig_q <= noteHit && noteTrig;
      noteSev_q <= noteHit ? `CLDIO_SEV_CRITICAL : 3'h0;
      noteChan_q <= noteHit ? noteIdx : 2'h0;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ctlOut = outLine_q;
  assign ctlOutOe = outOe_q;
  assign irq = irq_q;
  assign noteReq = noteReq_q;
  assign noteIsTrig = noteIsTrig_q;
  assign noteSev = noteSev_q;
  assign noteChan = noteChan_q;

  note_on_event_a: assert property (@(posedge core_clk) disable iff (rst)
    noteHit && noteMaskSel != 3'h0 |=> noteReq != 3'h0 && noteSev == `CLDIO_SEV_CRITICAL)
    else $error("notification missing after alarm event");
  fs_force_a: assert property (@(posedge core_clk) disable iff (rst)
    failsafeFire && outCfg_q[1:0] == 2'(FsActivate) |=> outVal_q[0])
    else $error("failsafe activate not applied");
  disabled_out_a: assert property (@(posedge core_clk) disable iff (rst)
    !outEn[0] |=> !ctlOut[0] && !ctlOutOe[0])
    else $error("disabled output driven");
  irq_level_a: assert property (@(posedge core_clk) disable iff (rst)
    |(irqStat_q & irqEn_q) |=> irq)
    else $error("interrupt not raised");
  sticky_set_a: assert property (@(posedge core_clk) disable iff (rst)
    trigEvt != '0 |=> (irqStat_q[`CLDIO_IRQ_TRIG_LSB +: NumIn] & $past(trigEvt)) == $past(trigEvt))
    else $error("trigger status bit lost");
  // Output and interrupt checks
  profile_off_a: assert property (@(posedge core_clk) disable iff (rst)
    !profileOn |=> ctlOutOe == '0)
    else $error("output driven outside the control-line profile");
  out_drive_a: assert property (@(posedge core_clk) disable iff (rst)
    outEn[1] |=> ctlOutOe[1] && ctlOut[1] == $past(outVal_q[1]))
    else $error("enabled output not driven");
  irq_low_a: assert property (@(posedge core_clk) disable iff (rst)
    (irqStat_q & irqEn_q) == '0 |=> !irq)
    else $error("interrupt without enabled status");
  out_val_a: assert property (@(posedge core_clk) disable iff (rst)
    wrCtrl && !failsafeFire |=> outVal_q == $past(hwdata[`CLDIO_OUTVAL_LSB +: NumOut]))
    else $error("output value write lost");
endmodule
`default_nettype wire

/* File: sim/cldio_equip.sv */
// Model of the serial equipment that drives the input lines and senses the output lines
`timescale 1ns/100ps
`default_nettype none
module cldio_equip
(
  input wire logic core_clk,
  input wire logic [2:0] want,
  output logic [2:0] lines,
  input wire logic [1:0] drv,
  input wire logic [1:0] drvOe,
  output logic [1:0] seen
);
  // Line levels move only just after a clock edge
  always @(posedge core_clk) lines <= want;
  // An undriven output reads low through its pull-down
  assign seen = drv & drvOe;
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Testbench for the control-line digital I/O block
`timescale 1ns/100ps
`default_nettype none
`include "cldio_map.svh"
module tb;
  import cldio_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = `CLDIO_HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic failsafeFire = 1'b0;
  logic [2:0] want = 3'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, irq, noteIsTrig;
  logic [2:0] ctlIn, noteReq, noteSev;
  logic [1:0] ctlOut, ctlOutOe, noteChan, seen;
  logic [8:0] note = 9'h0;
  int noteCount = 0;
  int n0 = 0;
  int err_total = 0;
  int check_count = 0;
  always #2 core_clk = ~core_clk;
  cldio_top i_dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ctlIn(ctlIn), .failsafeFire(failsafeFire), .ctlOut(ctlOut),
    .ctlOutOe(ctlOutOe), .irq(irq), .noteReq(noteReq), .noteIsTrig(noteIsTrig), .noteSev(noteSev),
    .noteChan(noteChan));
  cldio_equip i_equip (.core_clk(core_clk), .want(want), .lines(ctlIn), .drv(ctlOut), .drvOe(ctlOutOe),
    .seen(seen));
  // Keep the last notification pulse for later judging
  always @(posedge core_clk)
    if (noteReq !== 3'h0)
    begin
      note <= {noteReq, noteIsTrig, noteSev, noteChan};
      noteCount <= noteCount + 1;
    end
  task end_sim;
    $display("Errors %0d in %0d checks", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task rdy;
    int n;
    n = 0;
    @(posedge core_clk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        err_total++;
        $display("ERROR %0t bus hang", $time);
        end_sim;
      end
      @(posedge core_clk);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= `CLDIO_HTRANS_NONSEQ;
    hwrite <= w;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask
  task hold;
    repeat (8) @(posedge core_clk);
  endtask
  task fire;
    failsafeFire <= 1'b1;
    @(posedge core_clk);
    failsafeFire <= 1'b0;
    hold;
  endtask
  task t_reset;
    xfer(0, `CLDIO_OFS_CTRL, 0);
    chk(rd, 0);
    xfer(0, `CLDIO_OFS_INCFG, 0);
    chk(rd, 0);
    xfer(0, `CLDIO_OFS_OUTCFG, 0);
    chk(rd, 0);
    xfer(0, 8'h3c, 0);
    chk(rd, 0);
    chk(32'(ctlOutOe), 0);
    xfer(0, `CLDIO_OFS_NOTE, 0);
    chk(rd, 0);
    chk(32'(hresp), 0);
    chk(32'(hreadyout), 32'h1);
  endtask
  task t_outputs;
    xfer(1, `CLDIO_OFS_CTRL, 32'h13f);
    hold;
    chk(32'(seen), 32'h1);
    chk(32'(ctlOutOe), 32'h3);
    xfer(0, `CLDIO_OFS_STATUS, 0);
    chk(rd, 32'h8);
    xfer(1, `CLDIO_OFS_CTRL, 32'h130);
    want <= 3'h7;
    hold;
    chk(32'(ctlOutOe), 32'h2);
    chk(32'(seen), 0);
    xfer(0, `CLDIO_OFS_STATUS, 0);
    chk(32'(rd[2:0]), 0);
    want <= 3'h0;
  endtask
  task t_latch;
    xfer(1, `CLDIO_OFS_CTRL, 32'h3f);
    xfer(1, `CLDIO_OFS_INCFG, 32'h1);
    hold;
    want <= 3'h1;
    hold;
    xfer(0, `CLDIO_OFS_LATCH, 0);
    chk(rd, 32'h1);
    want <= 3'h0;
    hold;
    xfer(0, `CLDIO_OFS_LATCH, 0);
    chk(rd, 32'h1);
    xfer(1, `CLDIO_OFS_LATCH, 32'h1);
    xfer(0, `CLDIO_OFS_LATCH, 0);
    chk(rd, 0);
    want <= 3'h1;
    hold;
    xfer(0, `CLDIO_OFS_LATCH, 0);
    chk(rd, 32'h1);
    want <= 3'h0;
    xfer(1, `CLDIO_OFS_INCFG, 32'h40200);
    hold;
    xfer(0, `CLDIO_OFS_STATUS, 0);
    chk(32'(rd[2:0]), 32'h4);
    want <= 3'h2;
    hold;
    xfer(0, `CLDIO_OFS_LATCH, 0);
    chk(32'(rd[1]), 0);
    want <= 3'h0;
    hold;
    xfer(0, `CLDIO_OFS_LATCH, 0);
    chk(32'(rd[1]), 32'h1);
  endtask
  task t_alarm;
    xfer(1, `CLDIO_OFS_IRQCLR, 32'h1ff);
    xfer(1, `CLDIO_OFS_IRQEN, 32'h1ff);
    xfer(1, `CLDIO_OFS_NOTE, 32'h10000);
    xfer(1, `CLDIO_OFS_INCFG, 32'h00100000);
    hold;
    n0 = noteCount;
    want <= 3'h4;
    hold;
    xfer(0, `CLDIO_OFS_ALARM, 0);
    chk(rd, 32'h4);
    chk(32'(note), 32'h06a);
    chk(32'(irq), 32'h1);
    xfer(0, `CLDIO_OFS_IRQSTAT, 0);
    chk(32'(rd[5]), 32'h1);
    want <= 3'h0;
    hold;
    xfer(0, `CLDIO_OFS_ALARM, 0);
    chk(rd, 0);
    chk(32'(note), 32'h04a);
    chk(32'(noteCount - n0), 32'h2);
    xfer(1, `CLDIO_OFS_IRQCLR, 32'h1ff);
    hold;
    chk(32'(irq), 0);
  endtask
  task t_manual;
    xfer(1, `CLDIO_OFS_IRQEN, 0);
    xfer(1, `CLDIO_OFS_INCFG, 32'h00280000);
    want <= 3'h4;
    hold;
    want <= 3'h0;
    hold;
    xfer(0, `CLDIO_OFS_ALARM, 0);
    chk(rd, 32'h4);
    chk(32'(irq), 0);
    want <= 3'h4;
    hold;
    xfer(0, `CLDIO_OFS_ALARM, 0);
    chk(rd, 32'h4);
    xfer(1, `CLDIO_OFS_ACK, 32'h4);
    hold;
    xfer(0, `CLDIO_OFS_ALARM, 0);
    chk(rd, 0);
    xfer(1, `CLDIO_OFS_INCFG, 32'h0);
    n0 = noteCount;
    want <= 3'h0;
    hold;
    want <= 3'h4;
    hold;
    xfer(0, `CLDIO_OFS_ALARM, 0);
    chk(rd, 0);
    chk(32'(noteCount - n0), 0);
  endtask
  task t_failsafe;
    xfer(1, `CLDIO_OFS_CTRL, 32'h23f);
    xfer(1, `CLDIO_OFS_OUTCFG, 32'h9);
    fire;
    chk(32'(seen), 32'h1);
    xfer(1, `CLDIO_OFS_OUTCFG, 0);
    fire;
    chk(32'(seen), 32'h1);
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    t_reset;
    t_outputs;
    t_latch;
    t_alarm;
    t_manual;
    t_failsafe;
    end_sim;
  end
endmodule
`default_nettype wire
